// *** rtcrb_bank.sv ***
// What this block does
// R1: Four channel register sets beside shared set.
// R2: Selection persists until select register rewritten.
// R3: Address FF always selects the select register.
// R4: Channel bit 3 holds core in reset.
// R5: Channel bit 2 restores channel register defaults.
// R6: Channel bit 1 resets reference clock domain.
// R7: Channel bit 0 resets divider clock domain.
// R8: Lock loss flag sticky, cleared on read.
// R9: Signal loss flag set after signal lost.
// R10: Status bit 7 shows rate within tolerance.
// R11: Status bit 6 shows adaptation finished.
// R12: Status bit 5 shows signal insufficient.
// R13: Status bit 4 shows recovery locked.
// R14: Status bit 2 shows enough transitions.
// R15: Status bit 1 shows rate too high.
// R16: Forced boost applies only with force enable.
// R17: Channel access needs enable; reads use index.
// R18: Broadcast writes reach all four channels.
// R19: Host writes full select byte, upper zero.
// R20: Writes to read-only bits are ignored.
`timescale 1ns/1ps
`default_nettype none
module rtcrb_bank (
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic rst, // Async reset, active high
    input wire logic ce, // Clock enable, freezes all state
    input wire logic [7:0] host_addr, // Register address
    input wire logic host_wr, // Write strobe
    input wire logic [7:0] host_wdata, // Write data
    input wire logic host_rd, // Read strobe
    input wire logic [3:0] ppm_ok, // Per channel rate in tolerance
    input wire logic [3:0] adapt_done, // Per channel adaptation done
    input wire logic [3:0] lock_fail, // Per channel signal too poor
    input wire logic [3:0] cdr_locked, // Per channel recovery locked
    input wire logic [3:0] trans_met, // Per channel transitions met
    input wire logic [3:0] rate_high, // Per channel rate too high
    input wire logic [3:0] sig_detect, // Per channel signal present
    input wire logic [31:0] adapt_boost, // Adaptive boost, channel n at [8n+7:8n]
    output logic [7:0] host_rdata, // Read data
    output logic host_rvalid, // Read data valid pulse
    output logic channel_set_enable, // Channel sets selected
    output logic [3:0] core_hold, // Core reset per channel
    output logic [3:0] refclk_domain_reset, // Reference domain reset
    output logic [3:0] divider_domain_reset, // Divider domain reset
    output logic [31:0] eq_boost_out // Boost in use per channel
);
    logic [3:0] select_reg;
    logic broadcast_write;
    logic [1:0] target_channel_index;
    logic select_hit;
    logic [3:0] wr_targets;
    logic [3:0] rd_targets;
    logic [7:0] ch_rdata [rtcrb_pkg::NUM_CH];
    logic [7:0] sel_rdata;

    // Write masks for writes and reads; reads never broadcast
    function automatic logic [3:0] pick_targets(input logic [3:0] sel, input logic hit, input logic allow_all);
        logic [3:0] mask;
        mask = 4'h0;
        if (!hit && sel[rtcrb_pkg::CHANNEL_SET_ENABLE_BIT]) begin
            if (allow_all && sel[rtcrb_pkg::BROADCAST_WRITE_BIT]) begin
                mask = 4'hF;
            end else begin
                mask[sel[1:0]] = 1'b1;
            end
        end
        return mask;
    endfunction : pick_targets

    assign broadcast_write = select_reg[rtcrb_pkg::BROADCAST_WRITE_BIT];
    assign channel_set_enable = select_reg[rtcrb_pkg::CHANNEL_SET_ENABLE_BIT];
    assign target_channel_index = select_reg[rtcrb_pkg::TARGET_INDEX_LSB +: 2];
    assign select_hit = host_addr == rtcrb_pkg::ADDR_CHAN_SELECT; // R3
    assign wr_targets = pick_targets(select_reg, select_hit, 1'b1); // R18
    assign rd_targets = pick_targets(select_reg, select_hit, 1'b0); // R17
    assign sel_rdata = ch_rdata[target_channel_index];

    // Upper four bits are expected zero; they are not stored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            select_reg <= rtcrb_pkg::SELECT_RST;
        end else if (ce && host_wr && select_hit) begin
            select_reg <= host_wdata[3:0]; // R2
        end
    end

    // Select register cannot be read back; it answers a fixed value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            host_rdata <= rtcrb_pkg::UNMAPPED_READ_VALUE;
            host_rvalid <= 1'b0;
        end else if (ce) begin
            host_rvalid <= host_rd;
            if (host_rd) begin
                if (select_hit) begin
                    host_rdata <= rtcrb_pkg::SELECT_READ_VALUE; // R3
                end else if (channel_set_enable) begin
                    host_rdata <= sel_rdata; // R17
                end else begin
                    host_rdata <= rtcrb_pkg::UNMAPPED_READ_VALUE;
                end
            end
        end
    end

    generate
        for (genvar i = 0; i < rtcrb_pkg::NUM_CH; i++) begin : g_ch
            rtcrb_chan_if ch_bus ();
            assign ch_bus.addr = host_addr;
            assign ch_bus.wdata = host_wdata;
            assign ch_bus.wr = host_wr & wr_targets[i];
            assign ch_bus.rd = host_rd & rd_targets[i];
            assign ch_rdata[i] = ch_bus.rdata;
            rtcrb_channel u_channel ( // R1
                .sys_clk(sys_clk),
                .rst(rst),
                .ce(ce),
                .bus(ch_bus.chan),
                .ppm_ok(ppm_ok[i]),
                .adapt_done(adapt_done[i]),
                .lock_fail(lock_fail[i]),
                .cdr_locked(cdr_locked[i]),
                .trans_met(trans_met[i]),
                .rate_high(rate_high[i]),
                .sig_detect(sig_detect[i]),
                .adapt_boost(adapt_boost[8*i +: 8]),
                .core_hold(core_hold[i]),
                .refclk_domain_reset(refclk_domain_reset[i]),
                .divider_domain_reset(divider_domain_reset[i]),
                .eq_boost_out(eq_boost_out[8*i +: 8])
            );
        end
    endgenerate

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence select_write_s;
        ce && host_wr && select_hit;
    endsequence
    sequence channel_read_s;
        ce && host_rd && !select_hit && channel_set_enable;
    endsequence

    select_hold_a: assert property (!(ce && host_wr && select_hit) |=> select_reg == $past(select_reg)) // R2
        else $error("selection changed without select write");
    select_load_a: assert property (select_write_s |=> select_reg == $past(host_wdata[3:0])) // R3
        else $error("select write not taken");
    select_no_chan_a: assert property (select_hit |-> wr_targets == 4'h0 && rd_targets == 4'h0) // R3
        else $error("address FF reached a channel");
    select_read_a: assert property (ce && host_rd && select_hit |=> host_rvalid && host_rdata == 8'h00) // R3
        else $error("select read answer wrong");
    broadcast_all_a: assert property (!select_hit && channel_set_enable && broadcast_write |-> wr_targets == 4'hF) // R18
        else $error("broadcast missed a channel");
    single_target_a: assert property (!select_hit && channel_set_enable && !broadcast_write
        |-> wr_targets == (4'h1 << target_channel_index)) // R17
        else $error("write reached wrong channel");
    read_one_a: assert property (!select_hit && channel_set_enable |-> rd_targets == (4'h1 << target_channel_index)) // R17
        else $error("read not limited to indexed channel");
    shared_only_a: assert property (!channel_set_enable |-> wr_targets == 4'h0 ##0 rd_targets == 4'h0) // R17
        else $error("channel reached while disabled");
    read_route_a: assert property (channel_read_s |=> host_rvalid && host_rdata == $past(sel_rdata)) // R17
        else $error("channel read data wrong");
    rvalid_pulse_a: assert property (ce && !host_rd |=> !host_rvalid) // R17
        else $error("spurious read valid");
    bcast_reset_a: assert property (select_write_s ##2 (ce && host_wr && !select_hit && channel_set_enable
        && broadcast_write && host_addr == rtcrb_pkg::ADDR_RESET_CTRL
        && host_wdata[rtcrb_pkg::CORE_RESET_BIT]) |=> core_hold == 4'hF) // R4
        else $error("broadcast core reset not applied");
endmodule : rtcrb_bank
`default_nettype wire

// *** rtcrb_chan_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rtcrb_chan_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport bank (output addr, output wdata, output wr, output rd, input rdata);
    modport chan (input addr, input wdata, input wr, input rd, output rdata);
endinterface : rtcrb_chan_if
`default_nettype wire

// *** rtcrb_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcrb_channel (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    rtcrb_chan_if.chan bus, // Access from the bank
    input wire logic ppm_ok, // Rate within tolerance
    input wire logic adapt_done, // Equalizer adaptation done
    input wire logic lock_fail, // Signal too poor for lock
    input wire logic cdr_locked, // Recovery locked
    input wire logic trans_met, // Enough transitions seen
    input wire logic rate_high, // Rate above oscillator limit
    input wire logic sig_detect, // Input signal present
    input wire logic [7:0] adapt_boost, // Adaptive boost setting
    output logic core_hold, // Core state machine reset
    output logic refclk_domain_reset, // Reference clock domain reset
    output logic divider_domain_reset, // Divider domain reset
    output logic [7:0] eq_boost_out // Boost in use
);
    logic [7:0] reset_ctrl_reg;
    logic [7:0] forced_boost_reg;
    logic force_en_reg;
    logic lock_lost_reg;
    logic signal_lost_reg;
    logic lock_seen_reg;
    logic sig_seen_reg;
    logic [7:0] status_reg;
    logic regs_reset;
    logic lock_drop;
    logic sig_drop;
    logic flags_read;

    assign regs_reset = reset_ctrl_reg[rtcrb_pkg::REGS_RESET_BIT];
    assign core_hold = reset_ctrl_reg[rtcrb_pkg::CORE_RESET_BIT]; // R4
    assign refclk_domain_reset = reset_ctrl_reg[rtcrb_pkg::REFCLK_RESET_BIT]; // R6
    assign divider_domain_reset = reset_ctrl_reg[rtcrb_pkg::DIVIDER_RESET_BIT]; // R7
    assign lock_drop = lock_seen_reg & ~cdr_locked;
    assign sig_drop = sig_seen_reg & ~sig_detect;
    assign flags_read = bus.rd && bus.addr == rtcrb_pkg::ADDR_LOSS_FLAGS;

    // Register reset is self-clearing: it restores its own bit too
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_ctrl_reg <= rtcrb_pkg::RESET_CTRL_RST;
        end else if (ce) begin
            if (regs_reset) begin
                reset_ctrl_reg <= rtcrb_pkg::RESET_CTRL_RST; // R5
            end else if (bus.wr && bus.addr == rtcrb_pkg::ADDR_RESET_CTRL) begin
                reset_ctrl_reg <= bus.wdata & rtcrb_pkg::RESET_CTRL_MASK; // R4
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            forced_boost_reg <= rtcrb_pkg::FORCED_BOOST_RST;
            force_en_reg <= rtcrb_pkg::FORCE_EN_RST;
        end else if (ce) begin
            if (regs_reset) begin
                forced_boost_reg <= rtcrb_pkg::FORCED_BOOST_RST; // R5
                force_en_reg <= rtcrb_pkg::FORCE_EN_RST;
            end else if (bus.wr && bus.addr == rtcrb_pkg::ADDR_FORCED_BOOST) begin
                forced_boost_reg <= bus.wdata;
            end else if (bus.wr && bus.addr == rtcrb_pkg::ADDR_BOOST_FORCE_CTRL) begin
                force_en_reg <= bus.wdata[rtcrb_pkg::BOOST_FORCE_EN_BIT];
            end
        end
    end

    // Sticky flags: a new loss wins over a read or register reset in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lock_seen_reg <= 1'b0;
            sig_seen_reg <= 1'b0;
            lock_lost_reg <= 1'b0;
            signal_lost_reg <= 1'b0;
        end else if (ce) begin
            lock_seen_reg <= cdr_locked;
            sig_seen_reg <= sig_detect;
            lock_lost_reg <= lock_drop | (lock_lost_reg & ~flags_read & ~regs_reset); // R8
            signal_lost_reg <= sig_drop | (signal_lost_reg & ~regs_reset); // R9
        end
    end

    // Status is sampled only; host writes never reach it
    always_ff @(posedge sys_clk or posedge rst) begin // R20
        if (rst) begin
            status_reg <= rtcrb_pkg::RECOV_STATUS_RST;
        end else if (ce) begin // R11 R12 R14 R15
            status_reg <= {ppm_ok, adapt_done, lock_fail, cdr_locked, 1'b0, trans_met, rate_high, 1'b0}; // R10
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eq_boost_out <= rtcrb_pkg::FORCED_BOOST_RST;
        end else if (ce) begin
            eq_boost_out <= force_en_reg ? forced_boost_reg : adapt_boost; // R16
        end
    end

    always_comb begin
        case (bus.addr)
            rtcrb_pkg::ADDR_RESET_CTRL: bus.rdata = reset_ctrl_reg;
            rtcrb_pkg::ADDR_LOSS_FLAGS: bus.rdata = {3'h0, lock_lost_reg, 3'h0, signal_lost_reg};
            rtcrb_pkg::ADDR_RECOV_STATUS: bus.rdata = status_reg; // R13
            rtcrb_pkg::ADDR_FORCED_BOOST: bus.rdata = forced_boost_reg;
            rtcrb_pkg::ADDR_BOOST_FORCE_CTRL: bus.rdata = {4'h0, force_en_reg, 3'h0};
            default: bus.rdata = rtcrb_pkg::UNMAPPED_READ_VALUE;
        endcase
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence lock_dropped_s;
        ce && lock_seen_reg && !cdr_locked;
    endsequence
    lock_loss_set_a: assert property (lock_dropped_s |=> lock_lost_reg) // R8
        else $error("lock loss not flagged");
    read_clears_a: assert property (ce && flags_read && !lock_drop |=> !lock_lost_reg) // R8
        else $error("lock loss flag kept after read");
    sig_loss_set_a: assert property (ce && sig_seen_reg && !sig_detect |=> signal_lost_reg) // R9
        else $error("signal loss not flagged");
    regs_restore_a: assert property (ce && regs_reset |=> reset_ctrl_reg == 8'h00 && forced_boost_reg == 8'h00) // R5
        else $error("register reset did not restore defaults");
    forced_boost_a: assert property (ce && force_en_reg |=> eq_boost_out == $past(forced_boost_reg)) // R16
        else $error("forced boost not applied");
    status_lock_a: assert property (ce |=> status_reg[4] == $past(cdr_locked) && status_reg[7] == $past(ppm_ok)) // R13
        else $error("status byte out of step");
    status_ro_a: assert property (ce && bus.wr && bus.addr == rtcrb_pkg::ADDR_RECOV_STATUS
        |=> status_reg == $past({ppm_ok, adapt_done, lock_fail, cdr_locked, 1'b0, trans_met, rate_high, 1'b0})) // R20
        else $error("status altered by write");
endmodule : rtcrb_channel
`default_nettype wire

// *** rtcrb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcrb_host_model (
    input wire logic sys_clk, // System clock
    input wire logic [7:0] host_rdata, // Read data from bank
    input wire logic host_rvalid, // Read data valid
    output logic [7:0] host_addr, // Register address
    output logic host_wr, // Write strobe
    output logic [7:0] host_wdata, // Write data
    output logic host_rd // Read strobe
);
    initial begin
        host_addr = 8'h00;
        host_wr = 1'b0;
        host_wdata = 8'h00;
        host_rd = 1'b0;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge sys_clk);
        host_wr <= 1'b0;
        // Idle bus shows inverted leftovers, never stale values
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask : write
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        d = 8'hXX;
        @(posedge sys_clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge sys_clk);
        host_rd <= 1'b0;
        host_addr <= ~a;
        for (int n = 0; n < 4; n++) begin
            @(posedge sys_clk);
            if (host_rvalid === 1'b1) begin
                d = host_rdata;
                break;
            end
        end
    endtask : read
endmodule : rtcrb_host_model
`default_nettype wire

// *** rtcrb_pkg.sv ***
package rtcrb_pkg;
    localparam int NUM_CH = 4;
    // Register offsets
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOSS_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_RECOV_STATUS = 8'h02;
    localparam logic [7:0] ADDR_FORCED_BOOST = 8'h03;
    localparam logic [7:0] ADDR_BOOST_FORCE_CTRL = 8'h2D;
    localparam logic [7:0] ADDR_CHAN_SELECT = 8'hFF;
    // channel_reset_control fields
    localparam int CORE_RESET_BIT = 3;
    localparam int REGS_RESET_BIT = 2;
    localparam int REFCLK_RESET_BIT = 1;
    localparam int DIVIDER_RESET_BIT = 0;
    localparam logic [7:0] RESET_CTRL_MASK = 8'h0F;
    // channel_loss_flags fields
    localparam int LOCK_LOST_BIT = 4;
    localparam int SIGNAL_LOST_BIT = 0;
    // recovery_status fields
    localparam int ST_PPM_OK_BIT = 7;
    localparam int ST_ADAPT_DONE_BIT = 6;
    localparam int ST_LOCK_FAIL_BIT = 5;
    localparam int ST_LOCKED_BIT = 4;
    localparam int ST_TRANS_MET_BIT = 2;
    localparam int ST_RATE_HIGH_BIT = 1;
    // forced_boost_settings fields, two bits each; force enable bit of the force control register
    localparam int BOOST_STAGE_A_LSB = 6;
    localparam int BOOST_STAGE_B_LSB = 4;
    localparam int BOOST_STAGE_C_LSB = 2;
    localparam int BOOST_STAGE_D_LSB = 0;
    localparam int BOOST_FORCE_EN_BIT = 3;
    // Select register fields
    localparam int BROADCAST_WRITE_BIT = 3;
    localparam int CHANNEL_SET_ENABLE_BIT = 2;
    localparam int TARGET_INDEX_LSB = 0;
    // Reset values and fixed read answers
    localparam logic [7:0] RESET_CTRL_RST = 8'h00;
    localparam logic [7:0] LOSS_FLAGS_RST = 8'h00;
    localparam logic [7:0] RECOV_STATUS_RST = 8'h00;
    localparam logic [7:0] FORCED_BOOST_RST = 8'h00;
    localparam logic FORCE_EN_RST = 1'b0;
    localparam logic [3:0] SELECT_RST = 4'h0;
    localparam logic [7:0] SELECT_READ_VALUE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
endpackage : rtcrb_pkg

// *** test_rtcrb_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_rtcrb_bank;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] ppm_ok = 4'h0;
    logic [3:0] adapt_done = 4'h0;
    logic [3:0] lock_fail = 4'h0;
    logic [3:0] cdr_locked = 4'h0;
    logic [3:0] trans_met = 4'h0;
    logic [3:0] rate_high = 4'h0;
    logic [3:0] sig_detect = 4'h0;
    logic [31:0] adapt_boost = 32'h0;
    logic [7:0] host_addr, host_wdata, host_rdata;
    logic host_wr, host_rd, host_rvalid, channel_set_enable;
    logic [3:0] core_hold, refclk_domain_reset, divider_domain_reset;
    logic [31:0] eq_boost_out;
    logic [31:0] lfsr_state = 32'h507A;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int m_sel = 0;
    int m_ctrl[4] = '{0, 0, 0, 0};
    int m_lock[4] = '{0, 0, 0, 0};
    int m_sig[4] = '{0, 0, 0, 0};
    int m_boost[4] = '{0, 0, 0, 0};
    int m_force[4] = '{0, 0, 0, 0};

    always #2.5 sys_clk = ~sys_clk;

    rtcrb_bank rtcrb_bank_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce), .host_addr(host_addr),
        .host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd), .ppm_ok(ppm_ok),
        .adapt_done(adapt_done), .lock_fail(lock_fail), .cdr_locked(cdr_locked), .trans_met(trans_met),
        .rate_high(rate_high), .sig_detect(sig_detect), .adapt_boost(adapt_boost),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .channel_set_enable(channel_set_enable),
        .core_hold(core_hold), .refclk_domain_reset(refclk_domain_reset),
        .divider_domain_reset(divider_domain_reset), .eq_boost_out(eq_boost_out));
    rtcrb_host_model rtcrb_host_model_inst (.sys_clk(sys_clk), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
        .host_rd(host_rd));

    function automatic void lfsr_step();
        lfsr_state = lfsr_state[0] ? ((lfsr_state >> 1) ^ 32'hA3000000) : (lfsr_state >> 1);
    endfunction : lfsr_step
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("Checks: %0d, mismatches: %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        rtcrb_host_model_inst.write(a, d);
        if (a == 8'hFF) begin
            m_sel = d & 15;
        end else if (m_sel[2]) begin
            for (int c = 0; c < 4; c++) begin
                if (m_sel[3] || c == (m_sel & 3)) begin
                    case (a)
                        8'h00: m_ctrl[c] = d[2] ? 0 : (d & 15);
                        8'h03: m_boost[c] = d;
                        8'h2D: m_force[c] = d[3];
                        default: ;
                    endcase
                    // Register reset wipes the whole channel set
                    if (a == 8'h00 && d[2]) begin
                        m_lock[c] = 0;
                        m_sig[c] = 0;
                        m_boost[c] = 0;
                        m_force[c] = 0;
                    end
                end
            end
        end
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        logic [7:0] d;
        logic [7:0] e;
        int c;
        rtcrb_host_model_inst.read(a, d);
        c = m_sel & 3;
        e = 8'h00;
        if (a != 8'hFF && m_sel[2]) begin
            case (a)
                8'h00: e = 8'(m_ctrl[c]);
                8'h01: e = 8'(m_lock[c] * 16 + m_sig[c]);
                8'h02: e = {ppm_ok[c], adapt_done[c], lock_fail[c], cdr_locked[c], 1'b0, trans_met[c],
                    rate_high[c], 1'b0};
                8'h03: e = 8'(m_boost[c]);
                8'h2D: e = 8'(m_force[c] * 8);
                default: ;
            endcase
            if (a == 8'h01) m_lock[c] = 0;
        end
        check(d, e);
    endtask : reg_rd
    task automatic check_outputs();
        logic [31:0] eb;
        logic [3:0] ch, rh, dh;
        repeat (3) @(posedge sys_clk);
        for (int c = 0; c < 4; c++) begin
            ch[c] = m_ctrl[c][3];
            rh[c] = m_ctrl[c][1];
            dh[c] = m_ctrl[c][0];
            eb[8*c +: 8] = m_force[c] ? m_boost[c][7:0] : adapt_boost[8*c +: 8];
        end
        check(core_hold, ch);
        check(refclk_domain_reset, rh);
        check(divider_domain_reset, dh);
        check(eq_boost_out, eb);
        check(channel_set_enable, m_sel[2]);
    endtask : check_outputs
    task automatic set_inputs(input logic [3:0] lk, input logic [3:0] sd);
        @(posedge sys_clk);
        for (int c = 0; c < 4; c++) begin
            if (cdr_locked[c] && !lk[c]) m_lock[c] = 1;
            if (sig_detect[c] && !sd[c]) m_sig[c] = 1;
        end
        lfsr_step();
        cdr_locked <= lk;
        sig_detect <= sd;
        ppm_ok <= lfsr_state[3:0];
        adapt_done <= lfsr_state[7:4];
        lock_fail <= lfsr_state[11:8];
        trans_met <= lfsr_state[15:12];
        rate_high <= lfsr_state[19:16];
        lfsr_step();
        adapt_boost <= lfsr_state;
        repeat (3) @(posedge sys_clk);
    endtask : set_inputs

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        // Whole run needs a few hundred cycles
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        reg_rd(8'h00);
        reg_rd(8'hFF);
        set_inputs(4'hF, 4'hF);
        for (int c = 0; c < 4; c++) begin
            reg_wr(8'hFF, 8'h04 + c);
            for (int a = 0; a < 4; a++) reg_rd(a[7:0]);
            reg_wr(8'h00, 8'hF0 | ((c * 3) & 8'h0B));
            reg_wr(8'h01, 8'hFF);
            reg_wr(8'h02, 8'hFF);
            for (int a = 0; a < 3; a++) reg_rd(a[7:0]);
        end
        check_outputs();
        for (int k = 0; k < 6; k++) begin
            set_inputs(lfsr_state[23:20], lfsr_state[27:24]);
            for (int c = 0; c < 4; c++) begin
                reg_wr(8'hFF, 8'h04 + c);
                reg_rd(8'h02);
                reg_rd(8'h01);
                reg_rd(8'h01);
            end
        end
        reg_wr(8'hFF, 8'h0C);
        reg_wr(8'h03, 8'hA5);
        check_outputs();
        reg_wr(8'h2D, 8'h08);
        check_outputs();
        reg_wr(8'hFF, 8'h05);
        reg_wr(8'h03, 8'h5A);
        reg_wr(8'h2D, 8'h00);
        check_outputs();
        reg_wr(8'hFF, 8'h0E);
        reg_rd(8'h03);
        for (int c = 0; c < 4; c++) begin
            reg_wr(8'hFF, 8'h04 + c);
            reg_rd(8'h03);
            reg_rd(8'h2D);
        end
        set_inputs(4'hF, 4'hF);
        set_inputs(4'h0, 4'h0);
        reg_wr(8'hFF, 8'h06);
        reg_wr(8'h00, 8'h0C);
        check_outputs();
        for (int a = 0; a < 4; a++) reg_rd(a[7:0]);
        reg_rd(8'h2D);
        reg_wr(8'hFF, 8'h07);
        reg_rd(8'h01);
        reg_wr(8'hFF, 8'h0C);
        reg_wr(8'h00, 8'h08);
        check_outputs();
        reg_wr(8'hFF, 8'h00);
        reg_wr(8'h00, 8'h08);
        check_outputs();
        // Frozen clock enable must drop a select write
        @(posedge sys_clk);
        ce <= 1'b0;
        rtcrb_host_model_inst.write(8'hFF, 8'h04);
        ce <= 1'b1;
        check_outputs();
        final_report();
    end
endmodule : test_rtcrb_bank
`default_nettype wire
